// File: design/srsd_top.sv
`timescale 1ns/1ps

// How it works
// - prescale_select bits 6:4 divide bus clock by value plus one
// - rate_divider_select bits 2:0 divide prescaler output by two to power value+1
// - prescaler runs off bus clock; divider output is master bit clock
// - bit-rate register readable and writable at any time
// - status is read-only; unused bits read zero; writes do nothing
// - rx_full_flag at bit 7 sets when a transfer completes
// - rx_full_flag clears by status read seeing it set, then data read
// - tx_empty_flag at bit 5 set while transmit buffer has room
// - tx_empty_flag clears by status read seeing it set, then data write
// - data writes without prior status read seeing tx_empty_flag are ignored
// - interrupt requested while tx_empty_flag and tx_irq_enable are both set
// - tx_empty_flag sets each time a byte moves buffer to shifter
// - idle unit moves written byte to shifter; flag back within two cycles
// - on shift end a queued byte moves and flag sets; else nothing moves
// - master_fault_flag at bit 4 sets when master sees select input low
// - fault input only when master, fault detect on, select output off
// - master_fault_flag clears by status read seeing it, then control_one write
// - data read gives receive buffer; data write loads transmit buffer
// - in master mode loading the transmit buffer starts a transfer
// - unread receive buffer keeps old byte; new byte dropped silently
// - system_enable low aborts, empties buffers, clears rx flag, sets tx flag
// - rx_fault_irq_enable gates interrupts from rx_full_flag and master_fault_flag
module srsd_top
  import srsd_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic [srsd_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  output logic [1:0]                      s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  input  wire logic [srsd_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  output logic [31:0]                     s_axi_rdata_o,
  output logic [1:0]                      s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  input  wire logic                       xfer_done_i,
  input  wire logic [7:0]                 rx_byte_i,
  input  wire logic                       slave_select_n_i,
  output logic                            shift_load_o,
  output logic [7:0]                      shift_data_o,
  output logic                            bit_clk_o,
  output srsd_pkg::srsd_ctrl_t            ctrl_o,
  output logic                            irq_o
);
  import srsd_pkg::*;

  // ***************************************************
  // state
  // ***************************************************
  srsd_ctrl_t            ctrl;
  logic [7:0]            bit_rate;
  logic [7:0]            rx_buf;
  logic [7:0]            tx_buf;
  logic                  tx_full;
  logic                  busy;
  logic                  rx_flag;
  logic                  tx_flag;
  logic                  fault_flag;
  logic                  rx_arm;
  logic                  tx_arm;
  logic                  fault_arm;
  logic                  ss_meta;
  logic                  ss_sync;
  logic [2:0]            pre_l;
  logic [2:0]            rate_l;
  logic [2:0]            pre_cnt;
  logic [7:0]            rate_cnt;
  logic                  aw_got;
  logic                  w_got;
  logic [ADDR_W-1:0]     aw_addr;
  logic [7:0]            w_byte;
  logic                  w_lane;

  function automatic logic [7:0] rate_limit(input logic [2:0] sel);
    logic [8:0] span;
    span = 9'h002 << sel;
    rate_limit = 8'(span - 9'h001);
  endfunction

  // ***************************************************
  // bus decode
  // ***************************************************
  wire aw_take   = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take    = s_axi_wvalid_i & s_axi_wready_o;
  wire wr_exec   = aw_got & w_got & ~s_axi_bvalid_o;
  wire rd_take   = s_axi_arvalid_i & s_axi_arready_o;
  wire wr_ok     = wr_exec & w_lane;
  wire wr_c1     = wr_ok & (aw_addr == OFF_CTRL_ONE);
  wire wr_c2     = wr_ok & (aw_addr == OFF_CTRL_TWO);
  wire wr_br     = wr_ok & (aw_addr == OFF_BIT_RATE);
  wire wr_dreg   = wr_ok & (aw_addr == OFF_DATA);
  wire en        = ctrl.system_enable;
  wire wr_data   = wr_dreg & tx_arm & tx_flag & en;
  wire rd_status = rd_take & (s_axi_araddr_i == OFF_STATUS);
  wire rd_data   = rd_take & (s_axi_araddr_i == OFF_DATA);
  wire wr_mapped = (aw_addr == OFF_CTRL_ONE) | (aw_addr == OFF_CTRL_TWO)
                 | (aw_addr == OFF_BIT_RATE) | (aw_addr == OFF_STATUS)
                 | (aw_addr == OFF_DATA);
  wire rd_mapped = (s_axi_araddr_i == OFF_CTRL_ONE) | (s_axi_araddr_i == OFF_CTRL_TWO)
                 | (s_axi_araddr_i == OFF_BIT_RATE) | (s_axi_araddr_i == OFF_STATUS)
                 | (s_axi_araddr_i == OFF_DATA);

  wire next_aw_got = ~wr_exec & (aw_got | aw_take);
  wire next_w_got  = ~wr_exec & (w_got | w_take);
  wire next_bvalid = wr_exec | (s_axi_bvalid_o & ~s_axi_bready_i);
  wire next_rvalid = rd_take | (s_axi_rvalid_o & ~s_axi_rready_i);

  // ***************************************************
  // register views
  // ***************************************************
  wire [7:0] c1_view = {ctrl.rx_fault_irq_enable, ctrl.system_enable, ctrl.tx_irq_enable,
                        ctrl.master_select, 2'h0, ctrl.select_output_enable, 1'h0};
  wire [7:0] c2_view = {3'h0, ctrl.fault_detect_enable, 4'h0};
  wire [7:0] st_view = {rx_flag, 1'h0, tx_flag, fault_flag, 4'h0};
  wire [7:0] rd_byte = (s_axi_araddr_i == OFF_CTRL_ONE) ? c1_view :
                       (s_axi_araddr_i == OFF_CTRL_TWO) ? c2_view :
                       (s_axi_araddr_i == OFF_BIT_RATE) ? bit_rate :
                       (s_axi_araddr_i == OFF_STATUS)   ? st_view :
                       (s_axi_araddr_i == OFF_DATA)     ? rx_buf : 8'h00;

  // ***************************************************
  // buffers and flags
  // ***************************************************
  wire load_now  = en & tx_full & (~busy | xfer_done_i);
  wire rx_set    = en & busy & xfer_done_i & ~rx_flag;
  wire fault_in  = ctrl.master_select & ctrl.fault_detect_enable
                 & ~ctrl.select_output_enable;
  wire fault_set = en & fault_in & ~ss_sync;

  wire next_busy    = en & (load_now | (busy & ~xfer_done_i));
  wire next_tx_full = en & (wr_data | (tx_full & ~load_now));
  // set wins over clear on tx and fault flags; rx_full_flag sets only while clear, so there a clear wins
  wire next_tx_flag = ~en | load_now | (tx_flag & ~wr_data);
  wire next_rx_flag = en & (rx_set | (rx_flag & ~(rd_data & rx_arm)));
  wire next_fault   = fault_set | (fault_flag & ~(wr_c1 & fault_arm));
  wire next_tx_arm  = en & ((rd_status & tx_flag) | (tx_arm & ~wr_data));
  wire next_rx_arm  = en & ((rd_status & rx_flag) | (rx_arm & ~rd_data));
  wire next_flt_arm = (rd_status & fault_flag) | (fault_arm & ~wr_c1);
  wire next_irq     = (tx_flag & ctrl.tx_irq_enable)
                    | ((rx_flag | fault_flag) & ctrl.rx_fault_irq_enable);

  // ***************************************************
  // bit-rate generator
  // ***************************************************
  // rates are latched at load so a rewrite cannot tear a running count
  wire run      = en & ctrl.master_select & busy;
  wire pre_tick = (pre_cnt == pre_l);
  wire rate_end = (rate_cnt == rate_limit(rate_l));

  always_ff @(posedge clk_i) begin
    if (reset_i | load_now | ~run) begin
      pre_cnt  <= 3'h0;
      rate_cnt <= 8'h00;
    end else if (pre_tick) begin
      pre_cnt  <= 3'h0;
      rate_cnt <= rate_end ? 8'h00 : 8'(rate_cnt + 8'h01);
    end else begin
      pre_cnt  <= 3'(pre_cnt + 3'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_l  <= 3'h0;
      rate_l <= 3'h0;
    end else if (load_now) begin
      pre_l  <= bit_rate[BR_PRE_HI:BR_PRE_LO];
      rate_l <= bit_rate[BR_RATE_HI:BR_RATE_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bit_clk_o <= 1'b0;
    end else begin
      bit_clk_o <= run & ~load_now & pre_tick & rate_end;
    end
  end

  // ***************************************************
  // slave select synchroniser
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ss_meta <= 1'b1;
      ss_sync <= 1'b1;
    end else begin
      ss_meta <= slave_select_n_i;
      ss_sync <= ss_meta;
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl     <= CTRL_RESET;
      bit_rate <= BIT_RATE_RESET;
    end else begin
      if (wr_c1) begin
        ctrl.rx_fault_irq_enable  <= w_byte[C1_RIE_BIT];
        ctrl.system_enable        <= w_byte[C1_SE_BIT];
        ctrl.tx_irq_enable        <= w_byte[C1_TIE_BIT];
        ctrl.master_select        <= w_byte[C1_MS_BIT];
        ctrl.select_output_enable <= w_byte[C1_SELECT_OUTPUT_ENABLE_BIT];
      end
      if (wr_c2) begin
        ctrl.fault_detect_enable <= w_byte[C2_FDE_BIT];
      end
      if (wr_br) begin
        bit_rate <= w_byte & 8'h77;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_full    <= 1'b0;
      busy       <= 1'b0;
      tx_flag    <= 1'b1;
      rx_flag    <= 1'b0;
      fault_flag <= 1'b0;
      tx_arm     <= 1'b0;
      rx_arm     <= 1'b0;
      fault_arm  <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      tx_full    <= next_tx_full;
      busy       <= next_busy;
      tx_flag    <= next_tx_flag;
      rx_flag    <= next_rx_flag;
      fault_flag <= next_fault;
      tx_arm     <= next_tx_arm;
      rx_arm     <= next_rx_arm;
      fault_arm  <= next_flt_arm;
      irq_o      <= next_irq;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_buf       <= 8'h00;
      rx_buf       <= 8'h00;
      shift_load_o <= 1'b0;
      shift_data_o <= 8'h00;
      ctrl_o       <= CTRL_RESET;
    end else begin
      if (wr_data) tx_buf <= w_byte;
      if (rx_set) rx_buf <= rx_byte_i;
      shift_load_o <= load_now;
      if (load_now) shift_data_o <= tx_buf;
      ctrl_o       <= ctrl;
    end
  end

  // ***************************************************
  // axi4-lite slave
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_got          <= 1'b0;
      w_got           <= 1'b0;
      aw_addr         <= '0;
      w_byte          <= 8'h00;
      w_lane          <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else begin
      aw_got          <= next_aw_got;
      w_got           <= next_w_got;
      s_axi_awready_o <= ~next_aw_got & ~next_bvalid;
      s_axi_wready_o  <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid_o  <= next_bvalid;
      if (aw_take) aw_addr <= s_axi_awaddr_i;
      if (w_take) begin
        w_byte <= s_axi_wdata_i[7:0];
        w_lane <= s_axi_wstrb_i[0];
      end
      if (wr_exec) s_axi_bresp_o <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else begin
      s_axi_arready_o <= ~next_rvalid;
      s_axi_rvalid_o  <= next_rvalid;
      if (rd_take) begin
        s_axi_rdata_o <= {24'h00_0000, rd_byte};
        s_axi_rresp_o <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_tx_reload_time: assert property (
    (wr_data & ~busy & ~tx_full) |-> ##[1:2] (tx_flag & busy))
    else $error("tx_empty_flag not back within two cycles");

  a_unarmed_write: assert property (
    (wr_dreg & ~tx_arm) |=> (~$rose(tx_full) && $stable(tx_buf)))
    else $error("data write accepted without status read");

  a_rx_no_arm: assert property (
    (rd_data & ~rx_arm & rx_flag & en) |=> rx_flag)
    else $error("rx_full_flag cleared without status read");

  a_rx_capture: assert property (
    rx_set |=> (rx_flag && rx_buf == $past(rx_byte_i)))
    else $error("completed byte not captured");

  a_overrun_keep: assert property (
    (xfer_done_i & rx_flag & ~rd_data) |=> $stable(rx_buf))
    else $error("overrun overwrote receive buffer");

  a_status_zero: assert property (
    rd_status |=> (s_axi_rdata_o[6] == 1'b0 && s_axi_rdata_o[3:0] == 4'h0))
    else $error("unused status bits not zero");

  a_fault_gated: assert property (
    (~fault_in & ~fault_flag) |=> ~fault_flag)
    else $error("master_fault_flag set while fault input off");

  a_tx_irq_req: assert property (
    (tx_flag & ctrl.tx_irq_enable) |=> irq_o)
    else $error("tx interrupt not requested");

  a_disable_clear: assert property (
    ~en |=> (~rx_flag & tx_flag & ~busy & ~tx_full))
    else $error("disable did not reset buffers and flags");

  a_master_start: assert property (
    (wr_data & ~busy & ~tx_full) |-> ##2 (shift_load_o && shift_data_o == $past(w_byte, 2)))
    else $error("written byte did not start transfer");

  c_back_to_back: cover property (load_now & busy & xfer_done_i);
  c_overrun:      cover property (xfer_done_i & busy & rx_flag);
  c_fault_clear:  cover property (wr_c1 & fault_arm & fault_flag);
  c_bit_clock:    cover property (bit_clk_o ##[1:600] bit_clk_o);

endmodule

// File: design/srsd_pkg.sv
package srsd_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam int       ADDR_W      = 8;
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_BIT_RATE = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_DATA     = 8'h10;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int BR_PRE_HI   = 6;
  localparam int BR_PRE_LO   = 4;
  localparam int BR_RATE_HI  = 2;
  localparam int BR_RATE_LO  = 0;
  localparam int ST_RX_BIT   = 7;
  localparam int ST_TX_BIT   = 5;
  localparam int ST_FLT_BIT  = 4;
  localparam int C1_RIE_BIT  = 7;
  localparam int C1_SE_BIT   = 6;
  localparam int C1_TIE_BIT  = 5;
  localparam int C1_MS_BIT   = 4;
  localparam int C1_SELECT_OUTPUT_ENABLE_BIT = 1;
  localparam int C2_FDE_BIT  = 4;

  // ***************************************************
  // reset values and codes
  // ***************************************************
  localparam logic [7:0] BIT_RATE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam int         TX_RELOAD_CYCLES = 2;

  typedef struct packed {
    logic rx_fault_irq_enable;
    logic system_enable;
    logic tx_irq_enable;
    logic master_select;
    logic select_output_enable;
    logic fault_detect_enable;
  } srsd_ctrl_t;

  localparam srsd_ctrl_t CTRL_RESET = '0;

endpackage

// File: verif/srsd_shift_model.sv
`timescale 1ns/1ps

// ***************************************************
// shifter stand-in: answers each load with the inverted byte
// ***************************************************
module srsd_shift_model (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic       shift_load_i,
  input  wire logic [7:0] shift_data_i,
  output logic            xfer_done_o,
  output logic [7:0]      rx_byte_o
);
  int         cnt;
  logic [7:0] held;

  initial begin
    cnt = 0;
    held = 8'h00;
    xfer_done_o = 1'b0;
    rx_byte_o = 8'h00;
  end

  always @(posedge clk_i) begin
    xfer_done_o <= 1'b0;
    // byte lines toggle outside done so a stale value is never read as good
    rx_byte_o <= ~rx_byte_o;
    if (shift_load_i) begin
      held <= ~shift_data_i;
      cnt <= slow_i ? 40 : 6;
    end else if (cnt == 1) begin
      xfer_done_o <= 1'b1;
      rx_byte_o <= held;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// File: verif/srsd_top_tb.sv
`timescale 1ns/1ps

module srsd_top_tb;
  import srsd_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic        xfer_done, load, bclk, irq, ssn = 1'b1, slow = 1'b0, got;
  logic [7:0]  rx_byte, sdata;
  srsd_ctrl_t  ctrl;
  int          mismatches = 0, tests_run = 0, n;

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  srsd_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .xfer_done_i(xfer_done), .rx_byte_i(rx_byte),
    .slave_select_n_i(ssn), .shift_load_o(load), .shift_data_o(sdata),
    .bit_clk_o(bclk), .ctrl_o(ctrl), .irq_o(irq));

  srsd_shift_model u_far (.clk_i(clk_i), .slow_i(slow), .shift_load_i(load),
    .shift_data_i(sdata), .xfer_done_o(xfer_done), .rx_byte_o(rx_byte));

  // ***************************************************
  // helpers
  // ***************************************************
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang();
    mismatches++;
    results();
  endtask

  // aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) hang();
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) hang();
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_load(input int lim);
    got = 1'b0;
    for (n = 0; n < lim && !got; n++) begin
      @(posedge clk_i);
      got = (load === 1'b1);
    end
  endtask

  task automatic wait_done();
    for (n = 0; n < 200 && xfer_done !== 1'b1; n++) @(posedge clk_i);
    if (n == 200) hang();
    repeat (3) @(posedge clk_i);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset_map();
    rdr(OFF_STATUS);
    check("status reset", rd, 32'h20);
    rdr(OFF_BIT_RATE);
    check("bit rate reset", rd, {24'h0, BIT_RATE_RESET});
    wr(OFF_STATUS, 8'hff);
    rdr(OFF_STATUS);
    check("status after write", rd, 32'h20);
    rdr(8'h14);
    check("unmapped resp", rsp, RESP_SLVERR);
    check("unmapped data", rd, 32'h0);
    $display("test reset_map done");
  endtask

  task automatic t_rate();
    wr(OFF_BIT_RATE, 8'hff);
    rdr(OFF_BIT_RATE);
    check("bit rate fields", rd, 32'h77);
    wr(OFF_BIT_RATE, 8'h11);
    check("bit rate resp", rsp, RESP_OKAY);
    $display("test rate done");
  endtask

  // unarmed write dropped, armed write loads shifter at once
  task automatic t_tx_start();
    int gap;
    wr(OFF_CTRL_ONE, 8'h50);
    wr(OFF_DATA, 8'h11);
    wait_load(12);
    check("unarmed load", got, 1'b0);
    rdr(OFF_STATUS);
    slow <= 1'b1;
    wr(OFF_DATA, 8'ha5);
    wait_load(12);
    check("armed load", got, 1'b1);
    check("shift data", sdata, 8'ha5);
    rdr(OFF_STATUS);
    check("tx flag back", rd, 32'h20);
    for (n = 0; n < 100 && bclk !== 1'b1; n++) @(posedge clk_i);
    if (n == 100) hang();
    gap = 0;
    do begin
      @(posedge clk_i);
      gap++;
    end while (bclk !== 1'b1 && gap < 100);
    check("bit clock period", gap, 2 * 4);
    wait_done();
    slow <= 1'b0;
    rdr(OFF_STATUS);
    check("rx flag set", rd, 32'ha0);
    $display("test tx_start done");
  endtask

  // queue behind a busy shifter, overrun keeps old byte
  task automatic t_queue();
    // status read of the last test armed the clear, so this read empties rx
    rdr(OFF_DATA);
    check("first rx byte", rd, 32'h5a);
    // long shifts keep the second byte queued while status is read
    slow <= 1'b1;
    rdr(OFF_STATUS);
    wr(OFF_DATA, 8'h3c);
    wait_load(12);
    check("first load seen", got, 1'b1);
    check("first load", sdata, 8'h3c);
    rdr(OFF_STATUS);
    wr(OFF_DATA, 8'h96);
    rdr(OFF_STATUS);
    check("tx flag cleared", rd[5], 1'b0);
    wait_load(40);
    check("queued load seen", got, 1'b1);
    check("queued load", sdata, 8'h96);
    wait_done();
    slow <= 1'b0;
    wr(OFF_CTRL_ONE, 8'hd0);
    repeat (3) @(posedge clk_i);
    check("rx irq", irq, 1'b1);
    rdr(OFF_DATA);
    check("data without arm", rd, 32'hc3);
    rdr(OFF_STATUS);
    check("rx still set", rd, 32'ha0);
    rdr(OFF_DATA);
    rdr(OFF_STATUS);
    check("rx cleared", rd, 32'h20);
    wr(OFF_CTRL_ONE, 8'h70);
    repeat (3) @(posedge clk_i);
    check("tx irq", irq, 1'b1);
    wr(OFF_CTRL_ONE, 8'h50);
    repeat (3) @(posedge clk_i);
    check("irq masked", irq, 1'b0);
    $display("test queue done");
  endtask

  task automatic t_fault();
    wr(OFF_CTRL_TWO, 8'h10);
    wr(OFF_CTRL_ONE, 8'h52);
    ssn <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("ctrl out", ctrl, 32'h17);
    rdr(OFF_STATUS);
    check("no fault with output", rd, 32'h20);
    wr(OFF_CTRL_ONE, 8'hd0);
    repeat (6) @(posedge clk_i);
    rdr(OFF_STATUS);
    check("fault set", rd, 32'h30);
    check("fault irq", irq, 1'b1);
    ssn <= 1'b1;
    repeat (6) @(posedge clk_i);
    wr(OFF_CTRL_ONE, 8'h50);
    rdr(OFF_STATUS);
    check("fault cleared", rd, 32'h20);
    $display("test fault done");
  endtask

  task automatic t_disable();
    rdr(OFF_STATUS);
    wr(OFF_DATA, 8'h0f);
    wait_done();
    wr(OFF_CTRL_ONE, 8'h00);
    rdr(OFF_STATUS);
    check("status disabled", rd, 32'h20);
    $display("test disable done");
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset_map();
    t_rate();
    t_tx_start();
    t_queue();
    t_fault();
    t_disable();
    results();
  end
endmodule
